/* File: dv/frt_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// cpu bus master: one-cycle strobes from falling edges
// ************************************************
module frt_cpu_model (
   input wire logic clk,
   output logic [15:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_word,
   output logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata
);
   // idle bus at time zero
   initial
   begin
      bus_addr = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_word = 1'b0;
      bus_wdata = 16'h0000;
   end

   // write: request held over one rising edge, then scrambled
   task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
      @(negedge clk);
      bus_addr = a;
      bus_word = w;
      bus_wdata = (a == frt_pkg::TONE_ADDR) ? (d & 16'h000F) : d;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~bus_wdata;
   endtask

   // read: data taken in the cycle after the strobe edge
   task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
      @(negedge clk);
      bus_addr = a;
      bus_word = w;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      bus_addr = ~a;
      d = bus_rdata;
   endtask

   // counter byte pair: low byte first, high byte after a gap
   task automatic rd_pair(input int gap, output logic [15:0] d);
      logic [15:0] lo;
      logic [15:0] hi;
      rd(frt_pkg::CNT_ADDR, 1'b0, lo);
      repeat (gap) @(negedge clk);
      rd(frt_pkg::CNT_ADDR + 16'h0001, 1'b0, hi);
      d = {hi[7:0], lo[7:0]};
   endtask
endmodule
`default_nettype wire

/* File: dv/frt_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
      end \
   end
module frt_timer_tb_top;
   // ************************************************
   // signals, clock, instances
   // ************************************************
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sub_clk_pin = 1'b0; // subclock stands still unless pulsed
   logic capture_pin = 1'b0;
   logic port_latch = 1'b1; // port level seen while timer output is off
   logic [15:0] bus_addr, bus_wdata, bus_rdata;
   logic bus_wr, bus_rd, bus_word;
   logic timer_out_pin, tone_pin, match_irq;
   int fails = 0;
   int n_checks = 0;
   always #2 clk = ~clk; // 250 MHz

   frt_timer u_frt_timer (.clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .sub_clk_pin(sub_clk_pin), .capture_pin(capture_pin), .port_latch(port_latch),
      .timer_out_pin(timer_out_pin), .tone_pin(tone_pin), .match_irq(match_irq));
   frt_cpu_model u_frt_cpu_model (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   // ************************************************
   // helpers
   // ************************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
      u_frt_cpu_model.wr(a, w, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
      u_frt_cpu_model.rd(a, w, d);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // bounded wait for the match pulse
   task automatic wait_irq;
      int i;
      for (i = 0; i < 400 && match_irq !== 1'b1; i++)
         @(negedge clk);
      if (i >= 400)
      begin
         fails++;
         stop_test;
      end
   endtask
   // cycles up to the next rising tone edge, bounded
   task automatic rise(output int n);
      n = 0;
      while (tone_pin !== 1'b0 && n < 40000)
      begin
         @(negedge clk);
         n++;
      end
      while (tone_pin !== 1'b1 && n < 40000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 40000)
      begin
         fails++;
         stop_test;
      end
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   // reset values, byte access, unmapped and read-only places
   task automatic t_reset;
      logic [15:0] v;
      rd(frt_pkg::TMODE_ADDR, 1'b0, v);
      `CHK(v, 16'h0000)
      rd(frt_pkg::TONE_ADDR, 1'b0, v);
      `CHK(v, 16'h0000)
      rd(frt_pkg::CMP_ADDR, 1'b1, v);
      `CHK(v, 16'hFFFF)
      rd(16'hFF50, 1'b0, v);
      `CHK(v, 16'h0000)
      wr(frt_pkg::CMP_ADDR, 1'b0, 16'h0012);
      rd(frt_pkg::CMP_ADDR, 1'b1, v);
      `CHK(v, 16'hFF12)
      wr(frt_pkg::CNT_ADDR, 1'b1, 16'h8000);
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      `CHK(v < 16'h0040, 1'b1)
      `CHK(timer_out_pin, 1'b1)
   endtask
   // match pulse, output toggling gated by toggle_enable
   task automatic t_match;
      logic [15:0] v;
      logic [15:0] c;
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      wr(frt_pkg::CMP_ADDR, 1'b1, v + 16'h0020);
      rd(frt_pkg::CMP_ADDR, 1'b1, c);
      `CHK(c, v + 16'h0020)
      wr(frt_pkg::TMODE_ADDR, 1'b0, 16'h0009);
      `CHK(timer_out_pin, 1'b0)
      wait_irq;
      cyc(1);
      `CHK(match_irq, 1'b0)
      `CHK(timer_out_pin, 1'b1)
      rd(frt_pkg::TMODE_ADDR, 1'b0, v);
      `CHK(v, 16'h0089)
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      `CHK(v > c, 1'b1)
      wr(frt_pkg::TMODE_ADDR, 1'b0, 16'h0001);
      wr(frt_pkg::CMP_ADDR, 1'b1, v + 16'h0020);
      wait_irq;
      cyc(2);
      `CHK(timer_out_pin, 1'b1)
      wr(frt_pkg::TMODE_ADDR, 1'b0, 16'h0000);
      port_latch = 1'b0;
      cyc(1);
      `CHK(timer_out_pin, 1'b0)
   endtask
   // byte pair read stays coherent while the count runs on
   task automatic t_freeze;
      logic [15:0] a;
      logic [15:0] v;
      rd(frt_pkg::CNT_ADDR, 1'b1, a);
      u_frt_cpu_model.rd_pair(1100, v);
      `CHK(v - a < 16'h0008, 1'b1)
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      `CHK(v - a > 16'h0100, 1'b1)
      u_frt_cpu_model.rd_pair(2, a);
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      `CHK(v - a < 16'h0004, 1'b1)
   endtask
   // tick rate of each main clock tap
   task automatic t_rates;
      int s;
      int e;
      logic [15:0] a;
      logic [15:0] b;
      for (s = 0; s < 3; s++)
      begin
         e = (s == 0) ? 320 : (s == 1) ? 20 : 10;
         wr(frt_pkg::TMODE_ADDR, 1'b0, 16'(s << 1));
         rd(frt_pkg::CNT_ADDR, 1'b1, a);
         cyc(1278);
         rd(frt_pkg::CNT_ADDR, 1'b1, b);
         `CHK((int'(b - a) >= e - 1) && (int'(b - a) <= e + 1), 1'b1)
      end
   endtask
   // capture per edge code, subclock ticks by hand
   task automatic t_capture;
      int k;
      logic [1:0] m;
      logic [15:0] n;
      logic [15:0] c;
      logic [15:0] hi;
      logic [15:0] p;
      for (k = 0; k < 4; k++)
      begin
         m = 2'(k + 1);
         wr(frt_pkg::TMODE_ADDR, 1'b0, 16'h0006 | {10'h000, m, 4'h0});
         rd(frt_pkg::CNT_ADDR, 1'b1, n);
         capture_pin = 1'b1;
         cyc(5);
         rd(frt_pkg::CAP_ADDR, 1'b1, c);
         if (m[0])
            p = n;
         `CHK(c, p)
         sub_clk_pin = 1'b1;
         cyc(4);
         sub_clk_pin = 1'b0;
         cyc(4);
         rd(frt_pkg::CNT_ADDR, 1'b1, c);
         `CHK(c, n + 16'h0001)
         capture_pin = 1'b0;
         cyc(5);
         rd(frt_pkg::CAP_ADDR, 1'b0, c);
         rd(frt_pkg::CAP_ADDR + 16'h0001, 1'b0, hi);
         if (m[1])
            p = n + 16'h0001;
         `CHK({hi[7:0], c[7:0]}, p)
      end
   endtask
   // tone periods, enable, subclock lockout
   task automatic t_tone;
      int s;
      int n;
      int sh[7] = '{4, 5, 8, 9, 10, 11, 12};
      logic [15:0] v;
      wr(frt_pkg::TONE_ADDR, 1'b0, 16'h0001);
      rd(frt_pkg::CNT_ADDR, 1'b1, v);
      `CHK(v, 16'h0000)
      wr(frt_pkg::TMODE_ADDR, 1'b0, 16'h0000);
      for (s = 0; s < 7; s++)
      begin
         wr(frt_pkg::TONE_ADDR, 1'b0, 16'(s << 1) | 16'h0001);
         rd(frt_pkg::TONE_ADDR, 1'b0, v);
         `CHK(v, 16'(s << 1) | 16'h0001)
         rise(n);
         rise(n);
         `CHK(n, 4 << sh[s])
      end
      wr(frt_pkg::TONE_ADDR, 1'b0, 16'h0000);
      for (s = 0; s < 40; s++)
      begin
         cyc(1);
         `CHK(tone_pin, 1'b0)
      end
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      cyc(12);
      resetn = 1'b1;
      cyc(4);
      t_reset;
      t_match;
      t_freeze;
      t_rates;
      t_capture;
      t_tone;
      stop_test;
   end
endmodule
`default_nettype wire

/* File: include/frt_pkg.sv */
package frt_pkg;
   // ************************************************
   // register addresses on the cpu bus
   // ************************************************
   localparam logic [15:0] TMODE_ADDR = 16'hFF48; // timer_mode_control
   localparam logic [15:0] TONE_ADDR = 16'hFF49; // tone_control
   localparam logic [15:0] CMP_ADDR = 16'hFF4A; // compare, low byte
   localparam logic [15:0] CNT_ADDR = 16'hFF4C; // counter, low byte
   localparam logic [15:0] CAP_ADDR = 16'hFF4E; // capture, low byte

   // ************************************************
   // reset values
   // ************************************************
   localparam logic [7:0] TMODE_RESET = 8'h00;
   localparam logic [7:0] TONE_RESET = 8'h00;
   localparam logic [15:0] CMP_RESET = 16'hFFFF;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;

   // ************************************************
   // timer_mode_control fields
   // ************************************************
   localparam int TM_OUT_LEVEL = 7; // out_level, read-only
   localparam int TM_WRAP = 6; // wrap_flag
   localparam int TM_EDGE_HI = 5; // edge_sel_high
   localparam int TM_EDGE_LO = 4; // edge_sel_low
   localparam int TM_TOGGLE = 3; // toggle_enable
   localparam int TM_CLK_HI = 2; // clk_sel_high
   localparam int TM_CLK_LO = 1; // clk_sel_low
   localparam int TM_OUT_EN = 0; // out_enable

   // ************************************************
   // tone_control fields
   // ************************************************
   localparam int TN_SEL_HI = 3; // tone_sel_bit2
   localparam int TN_SEL_LO = 1; // tone_sel_bit0
   localparam int TN_OUT_EN = 0; // tone_out_en
   localparam logic [7:0] TONE_WMASK = 8'h0F; // upper nibble stays zero

   // ************************************************
   // prescaler tap masks, named by main clock cycles per tick
   // ************************************************
   localparam logic [6:0] PRE_MASK_4 = 7'h03;
   localparam logic [6:0] PRE_MASK_64 = 7'h3F;
   localparam logic [6:0] PRE_MASK_128 = 7'h7F;

   // ************************************************
   // enumerations
   // ************************************************
   typedef enum logic [1:0] {FRT_EDGE_OFF, FRT_EDGE_RISE, FRT_EDGE_FALL, FRT_EDGE_BOTH} frt_edge_t;
   typedef enum logic [1:0] {FRT_CLK_DIV4, FRT_CLK_DIV64, FRT_CLK_DIV128, FRT_CLK_SUB} frt_clk_t;
endpackage

/* File: rtl/frt_timer.sv */
// Notes on behaviour
// R1: match of count and compare raises match_irq
// R2: compare takes any value, resets to ones
// R3: software masks irq before compare rewrite
// R4: counter resets to zero, cpu readable
// R5: count undefined after stop release
// R6: byte reads go low then high
// R7: byte and word access to 16-bit registers
// R8: capture copies count, no reset value
// R9: read buffer holds a stable count
// R10: mode control writable, resets to zero
// R11: bit 7 reads timer output level
// R12: wrap flag set on overflow, software clears
// R13: edge select off, rise, fall, both
// R14: toggle enable gates output inversion on match
// R15: count clock div4, div64, div128, subclock
// R16: out enable routes timer output to pin
// R17: software masks irq before clock change
// R18: tone divides count clock by 2^4..2^13
// R19: tone enable drives wave onto tone pin
// R20: software writes zeros to upper tone bits
// R21: tone control writable, resets to zero
// R22: subclock with tone blocks capture and reads
// R23: low read freezes buffer, high read releases
// R24: capture loads count within two clocks
// R25: output starts low when enabled, toggles
// R26: counter increments per tick, wraps, sets flag
// R27: pin edges and ticks synchronised first
`timescale 1ns/1ps
`default_nettype none
module frt_timer #(
   parameter int TONE_WIDTH = 13
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   input wire logic sub_clk_pin,
   input wire logic capture_pin,
   input wire logic port_latch,
   output logic timer_out_pin,
   output logic tone_pin,
   output logic match_irq
);
   // ************************************************
   // reset release
   // ************************************************
   logic rst_s1_reg; // first stage
   logic rst_n; // released reset

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [2:0] sub_sync_reg; // subclock: two sync stages, one history
   logic [2:0] cap_sync_reg; // capture pin: two sync stages, one history

   // only stages 1 and 2 are read by logic
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sub_sync_reg <= 3'h0;
         cap_sync_reg <= 3'h0;
      end
      else
      begin
         sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_pin}; // R27
         cap_sync_reg <= {cap_sync_reg[1:0], capture_pin}; // R27
      end
   end

   // ************************************************
   // registers and state
   // ************************************************
   logic [7:0] tmode_reg; // bits 5..0 stored here, 7 and 6 separate
   logic [7:0] tone_reg; // tone_control
   logic [15:0] compare_value_reg;
   logic [15:0] free_count_reg; // free_count
   logic [15:0] capture_value_reg;
   logic [15:0] read_buf_reg; // counter read buffer
   logic frozen_reg; // buffer held between byte reads
   logic out_level_reg; // timer output level
   logic wrap_flag_reg;
   logic eq_prev_reg; // equality one cycle ago
   logic [6:0] pre_reg; // main clock prescaler
   logic [15:0] rdata_reg;

   // ************************************************
   // field wires
   // ************************************************
   wire frt_pkg::frt_edge_t edge_sel =
      frt_pkg::frt_edge_t'(tmode_reg[frt_pkg::TM_EDGE_HI:frt_pkg::TM_EDGE_LO]);
   wire frt_pkg::frt_clk_t clk_sel =
      frt_pkg::frt_clk_t'(tmode_reg[frt_pkg::TM_CLK_HI:frt_pkg::TM_CLK_LO]);
   wire toggle_enable = tmode_reg[frt_pkg::TM_TOGGLE];
   wire out_enable = tmode_reg[frt_pkg::TM_OUT_EN];
   wire [2:0] tone_sel = tone_reg[frt_pkg::TN_SEL_HI:frt_pkg::TN_SEL_LO];
   wire tone_out_en = tone_reg[frt_pkg::TN_OUT_EN];
   wire [7:0] tmode_view = {out_level_reg, wrap_flag_reg, tmode_reg[5:0]}; // R11

   // ************************************************
   // address decode
   // ************************************************
   wire sel_tmode = bus_addr == frt_pkg::TMODE_ADDR;
   wire sel_tone = bus_addr == frt_pkg::TONE_ADDR;
   wire sel_cmp_lo = bus_addr == frt_pkg::CMP_ADDR;
   wire sel_cmp_hi = bus_addr == frt_pkg::CMP_ADDR + 16'h0001;
   wire sel_cnt_lo = bus_addr == frt_pkg::CNT_ADDR;
   wire sel_cnt_hi = bus_addr == frt_pkg::CNT_ADDR + 16'h0001;
   wire sel_cap_lo = bus_addr == frt_pkg::CAP_ADDR;
   wire sel_cap_hi = bus_addr == frt_pkg::CAP_ADDR + 16'h0001;

   // byte writes use the low data lane, word writes both lanes
   wire wr_tmode = bus_wr & ~bus_word & sel_tmode; // R10
   wire wr_tone = bus_wr & ~bus_word & sel_tone; // R21
   wire wr_cmp_lo = bus_wr & sel_cmp_lo; // R7
   wire wr_cmp_hi = bus_wr & ((sel_cmp_lo & bus_word) | (sel_cmp_hi & ~bus_word)); // R7
   wire [7:0] cmp_hi_data = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];

   // subclock with tone enabled: capture, word counter reads and the byte read buffer hold are off
   wire sub_unsync = (clk_sel == frt_pkg::FRT_CLK_SUB) & tone_out_en; // R22
   wire rd_cnt_lo = bus_rd & ~bus_word & sel_cnt_lo & ~sub_unsync; // R23
   wire rd_cnt_hi = bus_rd & ~bus_word & sel_cnt_hi & ~sub_unsync; // R23

   // ************************************************
   // count clock selection
   // ************************************************
   wire tick4 = (pre_reg & frt_pkg::PRE_MASK_4) == frt_pkg::PRE_MASK_4;
   wire tick64 = (pre_reg & frt_pkg::PRE_MASK_64) == frt_pkg::PRE_MASK_64;
   wire tick128 = (pre_reg & frt_pkg::PRE_MASK_128) == frt_pkg::PRE_MASK_128;
   wire tick_sub = sub_sync_reg[1] & ~sub_sync_reg[2];
   logic count_tick; // one-cycle count enable

   // mux of the four count clocks
   always_comb
   begin
      case (clk_sel)
         frt_pkg::FRT_CLK_DIV4: count_tick = tick4; // R15
         frt_pkg::FRT_CLK_DIV64: count_tick = tick64; // R15
         frt_pkg::FRT_CLK_DIV128: count_tick = tick128; // R15
         default: count_tick = tick_sub; // R15
      endcase
   end

   // ************************************************
   // event wires
   // ************************************************
   wire count_eq = free_count_reg == compare_value_reg;
   wire match_pulse = count_eq & ~eq_prev_reg; // R1
   wire wrap_set = count_tick & (free_count_reg == frt_pkg::CNT_ALL_ONES); // R26
   wire cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];
   wire cap_fall = ~cap_sync_reg[1] & cap_sync_reg[2];
   wire cap_hit = ~sub_unsync & (((edge_sel == frt_pkg::FRT_EDGE_RISE) & cap_rise) |
      ((edge_sel == frt_pkg::FRT_EDGE_FALL) & cap_fall) |
      ((edge_sel == frt_pkg::FRT_EDGE_BOTH) & (cap_rise | cap_fall))); // R13
   wire en_rise = wr_tmode & bus_wdata[frt_pkg::TM_OUT_EN] & ~out_enable;

   // ************************************************
   // next values
   // ************************************************
   wire [15:0] free_count_next = count_tick ? free_count_reg + 16'h0001 : free_count_reg; // R26
   wire frozen_next = rd_cnt_lo ? 1'b1 : (rd_cnt_hi ? 1'b0 : frozen_reg); // R23
   wire [15:0] read_buf_next = (frozen_reg | rd_cnt_lo) ? read_buf_reg : free_count_reg; // R9
   wire wrap_flag_next = wrap_set | (wr_tmode ? (wrap_flag_reg & bus_wdata[frt_pkg::TM_WRAP])
      : wrap_flag_reg); // R12
   wire out_level_next = en_rise ? 1'b0 : (match_pulse & toggle_enable ? ~out_level_reg
      : out_level_reg); // R25

   // read data select, unmapped addresses answer zero
   logic [15:0] rdata_next;
   always_comb
   begin
      if (bus_word & sel_cmp_lo)
         rdata_next = compare_value_reg;
      else if (bus_word & sel_cnt_lo)
         rdata_next = sub_unsync ? 16'h0000 : free_count_reg; // R22
      else if (bus_word & sel_cap_lo)
         rdata_next = capture_value_reg;
      else if (bus_word)
         rdata_next = 16'h0000;
      else if (sel_tmode)
         rdata_next = {8'h00, tmode_view}; // R11
      else if (sel_tone)
         rdata_next = {8'h00, tone_reg};
      else if (sel_cmp_lo)
         rdata_next = {8'h00, compare_value_reg[7:0]};
      else if (sel_cmp_hi)
         rdata_next = {8'h00, compare_value_reg[15:8]};
      else if (sel_cnt_lo)
         rdata_next = {8'h00, read_buf_reg[7:0]}; // R6
      else if (sel_cnt_hi)
         rdata_next = {8'h00, read_buf_reg[15:8]}; // R6
      else if (sel_cap_lo)
         rdata_next = {8'h00, capture_value_reg[7:0]};
      else if (sel_cap_hi)
         rdata_next = {8'h00, capture_value_reg[15:8]};
      else
         rdata_next = 16'h0000;
   end

   // ************************************************
   // control registers
   // ************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmode_reg <= frt_pkg::TMODE_RESET; // R10
         tone_reg <= frt_pkg::TONE_RESET; // R21
         compare_value_reg <= frt_pkg::CMP_RESET; // R2
      end
      else
      begin
         if (wr_tmode)
            tmode_reg <= {2'b00, bus_wdata[5:0]};
         if (wr_tone)
            tone_reg <= bus_wdata[7:0] & frt_pkg::TONE_WMASK;
         if (wr_cmp_lo)
            compare_value_reg[7:0] <= bus_wdata[7:0]; // R2
         if (wr_cmp_hi)
            compare_value_reg[15:8] <= cmp_hi_data; // R2
      end
   end

   // ************************************************
   // counter, flags, read buffer; count after a stop
   // release is not kept defined
   // ************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         free_count_reg <= frt_pkg::CNT_RESET; // R4
         read_buf_reg <= frt_pkg::CNT_RESET;
         frozen_reg <= 1'b0;
         wrap_flag_reg <= 1'b0;
         out_level_reg <= 1'b0;
         eq_prev_reg <= 1'b0;
         pre_reg <= 7'h00;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         free_count_reg <= free_count_next; // R5
         read_buf_reg <= read_buf_next;
         frozen_reg <= frozen_next;
         wrap_flag_reg <= wrap_flag_next;
         out_level_reg <= out_level_next; // R14
         eq_prev_reg <= count_eq;
         pre_reg <= pre_reg + 7'h01;
         rdata_reg <= bus_rd ? rdata_next : 16'h0000;
      end
   end

   // capture register keeps no reset value
   always_ff @(posedge clk)
   begin
      if (cap_hit)
         capture_value_reg <= free_count_reg; // R8 R24
   end

   // ************************************************
   // tone divider and outputs
   // ************************************************
   logic tone_wave;
   frt_tone_div #(.WIDTH(TONE_WIDTH)) u_tone (
      .clk(clk),
      .rst_n(rst_n),
      .tick(count_tick),
      .tone_sel(tone_sel),
      .wave(tone_wave)
   );

   assign match_irq = match_pulse; // R1
   assign timer_out_pin = out_enable ? out_level_reg : port_latch; // R16
   assign tone_pin = tone_out_en & tone_wave; // R19
   assign bus_rdata = rdata_reg;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_match;
      $rose(count_eq) |-> match_irq ##1 !match_irq;
   endproperty
   a_match: assert property (p_match) else $error("no match pulse on equality"); // R1

   property p_cmp_write;
      wr_cmp_hi && wr_cmp_lo |=> compare_value_reg == $past(bus_wdata);
   endproperty
   a_cmp_write: assert property (p_cmp_write) else $error("compare word write lost"); // R2

   property p_count;
      count_tick |=> free_count_reg == $past(free_count_reg) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("counter did not step"); // R26

   property p_hold;
      !count_tick |=> $stable(free_count_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without tick"); // R4

   property p_wrap;
      wrap_set |=> wrap_flag_reg && free_count_reg == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("overflow not flagged"); // R12

   property p_level_read;
      bus_rd && !bus_word && sel_tmode |=> bus_rdata[7] == $past(out_level_reg);
   endproperty
   a_level_read: assert property (p_level_read) else $error("bit 7 not output level"); // R11

   property p_toggle;
      match_irq && !en_rise |=> out_level_reg == ($past(toggle_enable) ^ $past(out_level_reg));
   endproperty
   a_toggle: assert property (p_toggle) else $error("bad output inversion"); // R14

   property p_pin;
      out_enable && $past(out_enable) && !$past(match_irq) |-> $stable(timer_out_pin);
   endproperty
   a_pin: assert property (p_pin) else $error("timer pin moved without match"); // R16

   property p_freeze;
      rd_cnt_lo ##1 !rd_cnt_hi |=> $stable(read_buf_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("read buffer moved while held"); // R23

   property p_capture;
      cap_hit |=> capture_value_reg == $past(free_count_reg);
   endproperty
   a_capture: assert property (p_capture) else $error("capture not loaded"); // R24

   property p_cap_off;
      edge_sel == frt_pkg::FRT_EDGE_OFF |-> !cap_hit;
   endproperty
   a_cap_off: assert property (p_cap_off) else $error("capture while disabled"); // R13

   property p_start_low;
      en_rise |=> !out_level_reg && timer_out_pin == 1'b0;
   endproperty
   a_start_low: assert property (p_start_low) else $error("output not low on enable"); // R25

   c_match_toggle: cover property (match_irq && toggle_enable && out_enable);
   c_byte_pair: cover property (rd_cnt_lo ##[1:20] rd_cnt_hi);
   c_capture: cover property (cap_hit && edge_sel == frt_pkg::FRT_EDGE_BOTH);
   c_wrap: cover property (wrap_set);
endmodule
`default_nettype wire

/* File: rtl/frt_tone_div.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// tone divider: square wave from count clock ticks
// ************************************************
module frt_tone_div #(
   parameter int WIDTH = 13
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [2:0] tone_sel,
   output logic wave
);
   logic [WIDTH-1:0] div_reg; // tick counter
   logic [WIDTH-1:0] div_next;
   logic sel_bit; // chosen counter bit
   logic wave_reg;

   // counter bit n-1 gives a square wave at tick rate / 2^n
   always_comb
   begin
      div_next = tick ? div_reg + 1'b1 : div_reg;
      case (tone_sel)
         3'h0: sel_bit = div_reg[3]; // R18
         3'h1: sel_bit = div_reg[4];
         3'h2: sel_bit = div_reg[7];
         3'h3: sel_bit = div_reg[8];
         3'h4: sel_bit = div_reg[9];
         3'h5: sel_bit = div_reg[10];
         3'h6: sel_bit = div_reg[11];
         default: sel_bit = div_reg[12];
      endcase
   end

   // counter and registered wave
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_reg <= '0;
         wave_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         wave_reg <= sel_bit;
      end
   end

   assign wave = wave_reg;
endmodule
`default_nettype wire
